// File: hw/cxe_entry.sv
// exception entry unit: reset, break entry/return, interrupt acceptance
`timescale 1ns/1ps
module cxe_entry
  import cxe_pkg::*;
#(
  parameter logic [CXE_ADDR_W-1:0] RESET_VEC = 32'h0000_0000,
  parameter logic [CXE_ADDR_W-1:0] BREAK_VEC = 32'h0000_0020,
  parameter logic [CXE_ADDR_W-1:0] GEN_EXC_VEC = 32'h0000_0040,
  parameter bit HAS_MMU = 1'b0,
  parameter bit HAS_MPU = 1'b0,
  parameter bit HAS_SHADOW = 1'b1,
  parameter bit USE_EXT_CTRL = 1'b1,
  parameter int unsigned N_IRQ = CXE_NUM_IRQ
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // pipeline events
  input wire logic break_insn_i,
  input wire logic hw_break_i,
  input wire logic break_ret_i,
  input wire logic [CXE_ADDR_W-1:0] insn_pc_i,
  input wire logic [CXE_ADDR_W-1:0] break_return_addr_i,
  input wire logic keep_irqs_on_entry_i,
  // status write from software
  input wire logic status_wr_i,
  input wire logic [CXE_STAT_W-1:0] status_wdata_i,
  // external controller
  input wire logic ext_irq_ctrl_req_i,
  input wire logic [CXE_ADDR_W-1:0] handler_vector_i,
  input wire logic [CXE_LVL_W-1:0] req_priority_level_i,
  input wire logic [CXE_RS_W-1:0] req_shadow_set_i,
  input wire logic req_nonmaskable_i,
  // internal controller
  input wire logic [N_IRQ-1:0] irq_req_i,
  input wire logic [N_IRQ-1:0] irq_mask_reg_i,
  // status and redirect
  output logic [CXE_STAT_W-1:0] status_o,
  output logic [CXE_STAT_W-1:0] saved_break_state_o,
  output logic [N_IRQ-1:0] irq_waiting_reg_o,
  output logic redirect_o,
  output logic [CXE_ADDR_W-1:0] redirect_pc_o,
  output logic icache_inv_o,
  output logic [CXE_ADDR_W-1:0] icache_inv_addr_o,
  output logic rf_wr_o,
  output logic [4:0] rf_wr_idx_o,
  output logic [CXE_ADDR_W-1:0] rf_wr_data_o,
  output logic irq_ack_o,
  output cxe_state_t state_o
);
  initial begin
    if (N_IRQ < 1 || N_IRQ > CXE_NUM_IRQ) $error("bad N_IRQ");
  end
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [CXE_STAT_W-1:0] status_q, status_d;
  logic [CXE_STAT_W-1:0] bsave_q, bsave_d;
  logic [N_IRQ-1:0] wait_q;
  cxe_state_t state_q, state_d;
  logic redir_q, redir_d;
  logic [CXE_ADDR_W-1:0] rpc_q, rpc_d;
  logic inv_q, inv_d;
  logic rfw_q, rfw_d;
  logic [CXE_ADDR_W-1:0] rfd_q, rfd_d;
  logic ack_q, ack_d;
  logic [4:0] idx_q, idx_d;
  logic [CXE_ADDR_W-1:0] inv_addr_q;
  // ------------------------------------------------------------
  // interrupt decisions
  // ------------------------------------------------------------
  logic gie;
  logic [CXE_LVL_W-1:0] cur_il;
  logic [CXE_RS_W-1:0] cur_crs;
  logic [N_IRQ-1:0] waiting;
  logic int_take;
  logic ext_take;
  logic irq_take;
  logic brk_take;
  assign gie = status_q[CXE_ST_GIE];
  assign cur_il = status_q[CXE_ST_IL_LO +: CXE_LVL_W];
  assign cur_crs = status_q[CXE_ST_CRS_LO +: CXE_RS_W];
  cxe_int_ctrl #(
    .N_IRQ(N_IRQ)
  ) u_int (
    .irq_req_i(irq_req_i),
    .irq_mask_i(irq_mask_reg_i),
    .gie_i(gie),
    .waiting_o(waiting),
    .hw_irq_o(int_take)
  );
  cxe_ext_arb u_ext (
    .req_valid_i(ext_irq_ctrl_req_i),
    .req_priority_level_i(req_priority_level_i),
    .req_nonmaskable_i(req_nonmaskable_i),
    .gie_i(gie),
    .current_irq_level_i(cur_il),
    .take_o(ext_take)
  );
  // handler info sampled in one cycle, valid only with the request
  assign irq_take = USE_EXT_CTRL ? ext_take : int_take;
  assign brk_take = break_insn_i | hw_break_i;
  // ------------------------------------------------------------
  // status on break entry
  // ------------------------------------------------------------
  logic [CXE_STAT_W-1:0] brk_stat;
  always_comb begin
    brk_stat = status_q;
    brk_stat[CXE_ST_GIE] = 1'b0;
    if (HAS_MMU || HAS_MPU) begin
      brk_stat[CXE_ST_NPRIV] = 1'b0;
    end
    if (HAS_MMU) begin
      brk_stat[CXE_ST_EH] = 1'b1;
    end
    brk_stat[CXE_ST_PRS_LO +: CXE_RS_W] = cur_crs;
    brk_stat[CXE_ST_CRS_LO +: CXE_RS_W] = '0;
  end
  // ------------------------------------------------------------
  // status on interrupt entry
  // ------------------------------------------------------------
  logic [CXE_STAT_W-1:0] irq_stat;
  always_comb begin
    irq_stat = status_q;
    // nested interrupts need the enable left on
    irq_stat[CXE_ST_GIE] = USE_EXT_CTRL & keep_irqs_on_entry_i;
    if (USE_EXT_CTRL) begin
      if (!req_nonmaskable_i) begin
        irq_stat[CXE_ST_IL_LO +: CXE_LVL_W] = req_priority_level_i;
      end
      irq_stat[CXE_ST_PRS_LO +: CXE_RS_W] = cur_crs;
      if (HAS_SHADOW) begin
        irq_stat[CXE_ST_CRS_LO +: CXE_RS_W] = req_shadow_set_i;
      end
    end
    if (HAS_MMU) begin
      irq_stat[CXE_ST_EH] = 1'b1;
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic [CXE_ADDR_W-1:0] next_pc;
  logic [CXE_ADDR_W-1:0] irq_vec;
  assign next_pc = insn_pc_i + CXE_INSN_BYTES;
  // handler address used as a virtual address when translation exists
  assign irq_vec = USE_EXT_CTRL ? handler_vector_i : GEN_EXC_VEC;
  always_comb begin
    state_d = CXE_RUN;
    status_d = status_q;
    bsave_d = bsave_q;
    redir_d = 1'b0;
    rpc_d = rpc_q;
    inv_d = 1'b0;
    rfw_d = 1'b0;
    rfd_d = rfd_q;
    ack_d = 1'b0;
    case (state_q)
      CXE_RESET: begin
        redir_d = 1'b1;
        rpc_d = RESET_VEC;
      end
      CXE_RUN: begin
        if (status_wr_i) begin
          status_d = status_wdata_i;
        end
        // priority: break before interrupt, return lowest
        if (brk_take) begin
          state_d = CXE_BREAK;
          bsave_d = status_q;
          status_d = brk_stat;
          rfw_d = 1'b1;
          rfd_d = next_pc;
          redir_d = 1'b1;
          rpc_d = BREAK_VEC;
        end else if (irq_take) begin
          state_d = CXE_IRQ;
          status_d = irq_stat;
          ack_d = 1'b1;
          redir_d = 1'b1;
          rpc_d = irq_vec;
        end else if (break_ret_i) begin
          status_d = bsave_q;
          redir_d = 1'b1;
          rpc_d = break_return_addr_i;
        end
      end
      CXE_BREAK, CXE_IRQ: begin
        state_d = CXE_RUN;
      end
      default: begin
        state_d = CXE_RUN;
      end
    endcase
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= CXE_RESET;
      status_q <= CXE_STAT_RST;
      bsave_q <= '0;
      redir_q <= 1'b0;
      rpc_q <= '0;
      inv_q <= 1'b1;
      rfw_q <= 1'b0;
      rfd_q <= '0;
      ack_q <= 1'b0;
      idx_q <= CXE_REG_ZERO;
      inv_addr_q <= RESET_VEC;
      wait_q <= '0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      bsave_q <= bsave_d;
      redir_q <= redir_d;
      rpc_q <= rpc_d;
      inv_q <= inv_d;
      rfw_q <= rfw_d;
      rfd_q <= rfd_d;
      ack_q <= ack_d;
      idx_q <= idx_d;
      inv_addr_q <= RESET_VEC;
      wait_q <= waiting;
    end
  end
  // only register 30 is ever written; register zero is never a target
  assign idx_d = rfw_d ? CXE_REG_BRA : CXE_REG_ZERO;
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign status_o = status_q;
  assign saved_break_state_o = bsave_q;
  assign irq_waiting_reg_o = wait_q;
  assign redirect_o = redir_q;
  assign redirect_pc_o = rpc_q;
  assign icache_inv_o = inv_q;
  // only the reset-vector line; rest of cache left to software
  assign icache_inv_addr_o = inv_addr_q;
  assign rf_wr_o = rfw_q;
  assign rf_wr_idx_o = idx_q;
  assign rf_wr_data_o = rfd_q;
  assign irq_ack_o = ack_q;
  assign state_o = state_q;
endmodule // cxe_entry

// File: hw/cxe_ext_arb.sv
// acceptance test for requests from the external interrupt controller
`timescale 1ns/1ps
module cxe_ext_arb
  import cxe_pkg::*;
(
  // request from the far controller
  input wire logic req_valid_i,
  input wire logic [CXE_LVL_W-1:0] req_priority_level_i,
  input wire logic req_nonmaskable_i,
  // current status
  input wire logic gie_i,
  input wire logic [CXE_LVL_W-1:0] current_irq_level_i,
  // decision
  output logic take_o
);
  logic mask_ok;
  assign mask_ok = gie_i & (req_priority_level_i > current_irq_level_i);
  // level and enable both bypassed for nonmaskable requests
  assign take_o = req_valid_i & (req_nonmaskable_i | mask_ok);
endmodule // cxe_ext_arb

// File: hw/cxe_int_ctrl.sv
// internal 32-input interrupt controller
`timescale 1ns/1ps
module cxe_int_ctrl
  import cxe_pkg::*;
#(
  parameter int unsigned N_IRQ = CXE_NUM_IRQ
) (
  // requests and control
  input wire logic [N_IRQ-1:0] irq_req_i,
  input wire logic [N_IRQ-1:0] irq_mask_i,
  input wire logic gie_i,
  // results
  output logic [N_IRQ-1:0] waiting_o,
  output logic hw_irq_o
);
  initial begin
    if (N_IRQ < 1 || N_IRQ > CXE_NUM_IRQ) $error("bad N_IRQ");
  end
  genvar n;
  for (n = 0; n < N_IRQ; n++) begin : g_irq
    assign waiting_o[n] = irq_req_i[n] & irq_mask_i[n];
  end
  assign hw_irq_o = gie_i & (|waiting_o);
endmodule // cxe_int_ctrl

// File: hw/cxe_pkg.sv
// shared constants and types for the exception entry unit
package cxe_pkg;
  localparam int unsigned CXE_ADDR_W = 32;
  localparam int unsigned CXE_NUM_IRQ = 32;
  localparam int unsigned CXE_LVL_W = 6;
  localparam int unsigned CXE_RS_W = 6;
  localparam int unsigned CXE_STAT_W = 32;
  // status field positions
  localparam int unsigned CXE_ST_GIE = 0;
  localparam int unsigned CXE_ST_NPRIV = 1;
  localparam int unsigned CXE_ST_EH = 2;
  localparam int unsigned CXE_ST_IL_LO = 3;
  localparam int unsigned CXE_ST_CRS_LO = 10;
  localparam int unsigned CXE_ST_PRS_LO = 16;
  localparam int unsigned CXE_ST_RESET_SHADOW_IRQ_ENABLE = 23;
  localparam logic [CXE_STAT_W-1:0] CXE_STAT_RST = 32'h0080_0000;
  localparam logic [CXE_ADDR_W-1:0] CXE_INSN_BYTES = 32'h0000_0004;
  localparam logic [4:0] CXE_REG_ZERO = 5'h00;
  localparam logic [4:0] CXE_REG_BRA = 5'h1E;
  // entry sequencer states, one-hot
  typedef enum logic [3:0] {
    CXE_RUN = 4'h1,
    CXE_RESET = 4'h2,
    CXE_BREAK = 4'h4,
    CXE_IRQ = 4'h8
  } cxe_state_t;
endpackage

// File: test/cxe_eic_model.sv
// far-side external interrupt controller model
`timescale 1ns/1ps
module cxe_eic_model
  import cxe_pkg::*;
(
  // core side
  input wire logic ref_clk_i,
  input wire logic irq_ack_i,
  // request bundle
  output logic req_o,
  output logic [CXE_ADDR_W-1:0] vec_o,
  output logic [CXE_LVL_W-1:0] lvl_o,
  output logic [CXE_RS_W-1:0] rs_o,
  output logic nm_o
);
  logic got;
  initial begin
    {req_o, lvl_o, rs_o, nm_o} = '0;
    vec_o = 32'hFFFF_FFFF;
    got = 1'b0;
  end
  // holds the whole bundle until acked or cyc edges pass
  task automatic raise(input logic [31:0] v, input logic [5:0] l,
                       input logic [5:0] s, input logic n, input int cyc);
    got = 1'b0;
    @(posedge ref_clk_i);
    #1 {req_o, vec_o, lvl_o, rs_o, nm_o} = {1'b1, v, l, s, n};
    // ack looked at once settled, not in the edge's own time step
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if (irq_ack_i === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
    // released bundle shows inverted fields, never the stale ones
    {req_o, vec_o, lvl_o, rs_o, nm_o} = {1'b0, ~v, ~l, ~s, ~n};
  endtask
endmodule // cxe_eic_model

// File: test/cxe_entry_properties.sv
// assertion checker for the exception entry unit
`timescale 1ns/1ps
module cxe_entry_chk
  import cxe_pkg::*;
#(
  parameter logic [CXE_ADDR_W-1:0] RESET_VEC = 32'h0000_0000,
  parameter logic [CXE_ADDR_W-1:0] BREAK_VEC = 32'h0000_0020
) (
  // watched ports
  input wire logic ref_clk_i, rstn_i, break_insn_i, hw_break_i, break_ret_i,
  input wire logic ext_irq_ctrl_req_i, req_nonmaskable_i, redirect_o,
  input wire logic icache_inv_o, rf_wr_o, irq_ack_o, keep_irqs_on_entry_i,
  input wire logic [31:0] insn_pc_i, break_return_addr_i, handler_vector_i,
  input wire logic [31:0] irq_req_i, irq_mask_reg_i, status_o,
  input wire logic [31:0] saved_break_state_o, irq_waiting_reg_o,
  input wire logic [31:0] redirect_pc_o, rf_wr_data_o,
  input wire logic [5:0] req_priority_level_i, req_shadow_set_i,
  input wire logic [4:0] rf_wr_idx_o,
  input wire cxe_state_t state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [5:0] il = status_o[CXE_ST_IL_LO +: CXE_LVL_W];
  wire logic [5:0] current_reg_set = status_o[CXE_ST_CRS_LO +: CXE_RS_W];
  wire logic [5:0] previous_reg_set = status_o[CXE_ST_PRS_LO +: CXE_RS_W];
  wire logic brk = break_insn_i || hw_break_i;
  sequence brk_take;
    state_o == CXE_RUN && brk;
  endsequence
  sequence ext_take;
    state_o == CXE_RUN && ext_irq_ctrl_req_i && !brk && (req_nonmaskable_i
      || (status_o[CXE_ST_GIE] && req_priority_level_i > il));
  endsequence
  reset_status_a: assert property (disable iff (1'b0)
    !rstn_i |=> status_o == CXE_STAT_RST && icache_inv_o) else $error("reset");
  reset_fetch_a: assert property (
    state_o == CXE_RESET |=> redirect_o && redirect_pc_o == RESET_VEC
    && !icache_inv_o) else $error("reset fetch");
  break_vec_a: assert property (
    brk_take |=> redirect_o && redirect_pc_o == BREAK_VEC) else $error("bvec");
  break_save_a: assert property (
    brk_take |=> saved_break_state_o == $past(status_o)
    && !status_o[CXE_ST_GIE]) else $error("break save");
  break_link_a: assert property (
    brk_take |=> rf_wr_o && rf_wr_idx_o == CXE_REG_BRA
    && rf_wr_data_o == $past(insn_pc_i) + CXE_INSN_BYTES) else $error("link");
  break_sets_a: assert property (
    brk_take |=> previous_reg_set == $past(current_reg_set) && current_reg_set == 6'h00) else $error("reg sets");
  break_ret_a: assert property (
    state_o == CXE_RUN && break_ret_i && !brk && !ext_irq_ctrl_req_i
    |=> status_o == $past(saved_break_state_o)
    && redirect_pc_o == $past(break_return_addr_i)) else $error("bret");
  ext_take_a: assert property (
    ext_take |=> irq_ack_o && redirect_pc_o == $past(handler_vector_i)
    && current_reg_set == $past(req_shadow_set_i)) else $error("ext take");
  ext_refuse_a: assert property (
    state_o == CXE_RUN && ext_irq_ctrl_req_i && !req_nonmaskable_i
    && req_priority_level_i <= il |=> !irq_ack_o) else $error("ext refuse");
  irq_gie_a: assert property (
    ext_take |=> status_o[CXE_ST_GIE] == $past(keep_irqs_on_entry_i))
    else $error("irq enable");
  irq_wait_a: assert property (
    $past(rstn_i) |-> irq_waiting_reg_o == $past(irq_req_i & irq_mask_reg_i))
    else $error("waiting");
endmodule // cxe_entry_chk
bind cxe_entry cxe_entry_chk #(.RESET_VEC(RESET_VEC), .BREAK_VEC(BREAK_VEC))
  i_chk (.ref_clk_i, .rstn_i, .break_insn_i, .hw_break_i, .break_ret_i,
  .ext_irq_ctrl_req_i, .req_nonmaskable_i, .redirect_o, .icache_inv_o,
  .rf_wr_o, .irq_ack_o, .insn_pc_i, .break_return_addr_i, .handler_vector_i,
  .irq_req_i, .irq_mask_reg_i, .status_o, .saved_break_state_o,
  .irq_waiting_reg_o, .redirect_pc_o, .rf_wr_data_o, .req_priority_level_i,
  .req_shadow_set_i, .rf_wr_idx_o, .state_o, .keep_irqs_on_entry_i);

// File: test/tb.sv
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
module tb;
  import cxe_pkg::*;
  logic ref_clk_i, rstn_i, break_insn_i, hw_break_i, break_ret_i, status_wr_i;
  logic keep_irqs_on_entry_i, ext_irq_ctrl_req_i, req_nonmaskable_i;
  logic redirect_o, icache_inv_o, rf_wr_o, irq_ack_o;
  logic [31:0] insn_pc_i, break_return_addr_i, status_wdata_i;
  logic [31:0] handler_vector_i, irq_req_i, irq_mask_reg_i, status_o;
  logic [31:0] saved_break_state_o, irq_waiting_reg_o, redirect_pc_o;
  logic [31:0] icache_inv_addr_o, rf_wr_data_o;
  logic [5:0] req_priority_level_i, req_shadow_set_i;
  logic [4:0] rf_wr_idx_o;
  cxe_state_t state_o;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  cxe_entry i_dut (.*);
  cxe_eic_model i_eic (.ref_clk_i, .irq_ack_i(irq_ack_o),
    .req_o(ext_irq_ctrl_req_i), .vec_o(handler_vector_i),
    .lvl_o(req_priority_level_i), .rs_o(req_shadow_set_i),
    .nm_o(req_nonmaskable_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle request; returns just after the edge that took it
  task automatic hit(ref logic s);
    @(posedge ref_clk_i);
    #1 s = 1'b1;
    @(posedge ref_clk_i);
    #1 s = 1'b0;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {break_insn_i, hw_break_i, break_ret_i, status_wr_i} = '0;
    keep_irqs_on_entry_i = 1'b0;
    rstn_i = 1'b0;
    insn_pc_i = 32'h0000_0100;
    break_return_addr_i = 32'h0000_0204;
    status_wdata_i = 32'h0000_1419;
    {irq_req_i, irq_mask_reg_i} = '0;
    repeat (5) @(posedge ref_clk_i);
    #1 chk("rst status", status_o, CXE_STAT_RST);
    chk("inv addr", icache_inv_addr_o, 32'h0000_0000);
    rstn_i = 1'b1;
    hit(status_wr_i);
    chk("wr status", status_o, 32'h0000_1419);
    hit(hw_break_i);
    chk("bk pc", redirect_pc_o, 32'h0000_0020);
    chk("bk saved", saved_break_state_o, 32'h0000_1419);
    chk("bk status", status_o, 32'h0005_0018);
    chk("bk link", rf_wr_data_o, 32'h0000_0104);
    chk("bk idx", {27'h0, rf_wr_idx_o}, 32'h0000_001E);
    hit(break_ret_i);
    chk("ret status", status_o, 32'h0000_1419);
    chk("ret pc", redirect_pc_o, 32'h0000_0204);
    // level equal to current level must be refused
    i_eic.raise(32'h0000_0300, 6'h03, 6'h02, 1'b0, 4);
    chk("lvl eq", {31'h0, i_eic.got}, 32'h0);
    i_eic.raise(32'h0000_0300, 6'h04, 6'h02, 1'b0, 4);
    chk("lvl gt", {31'h0, i_eic.got}, 32'h1);
    chk("ext pc", redirect_pc_o, 32'h0000_0300);
    chk("ext set", {26'h0, status_o[15:10]}, 32'h2);
    chk("ext gie", {31'h0, status_o[0]}, 32'h0);
    // enable now off and level high: only a nonmaskable gets in
    keep_irqs_on_entry_i = 1'b1;
    i_eic.raise(32'h0000_0400, 6'h00, 6'h01, 1'b1, 4);
    chk("nmi", {31'h0, i_eic.got}, 32'h1);
    chk("nmi gie", {31'h0, status_o[0]}, 32'h1);
    chk("nmi pc", redirect_pc_o, 32'h0000_0400);
    fork
      begin
        hit(break_insn_i);
        chk("prio pc", redirect_pc_o, 32'h0000_0020);
        chk("prio ack", {31'h0, irq_ack_o}, 32'h0);
      end
      i_eic.raise(32'h0000_0500, 6'h00, 6'h00, 1'b1, 6);
    join
    chk("brk nmi", {31'h0, i_eic.got}, 32'h1);
    chk("brk nmi pc", redirect_pc_o, 32'h0000_0500);
    irq_req_i = 32'hF0F0_0001;
    irq_mask_reg_i = 32'h0000_FFFF;
    repeat (2) @(posedge ref_clk_i);
    #1 chk("waiting", irq_waiting_reg_o, 32'h0000_0001);
    summarize();
  end
endmodule // tb
